// >>> bench/bps_boiler_model.sv
// bps_boiler_model: boiler controllers that obey the staging block's enables
// assumes one aclk domain; a burner lights one cycle after its enable
`timescale 1ns/1ps
module bps_boiler_model (
    input  wire logic       aclk,
    input  wire logic [7:0] boiler_fire,
    output logic      [3:0] lit
);
    // ********************
    // burners
    // ********************
    // lit counts the enabled channels, not one bit per boiler; all eight firing gives 8
    always_ff @(posedge aclk) begin
        lit <= 4'($countones(boiler_fire));
    end
endmodule // bps_boiler_model

// >>> bench/testbench.sv
// testbench: drives the staging block over AXI4-Lite against a small model
// assumes bps_pkg is compiled first; the second tick is cut to 20 cycles
`timescale 1ns/1ps
module testbench import bps_pkg::*;;
    logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0;
    logic arvalid = '0, rready = '0;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, d;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  r;
    bps_keys_t   keys_pin = '0;
    logic [9:0]  supply_temp = 10'h0B4, reset_setpoint = 10'h0B4;
    logic [9:0]  external_setpoint = 10'h0B4;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] boiler_fire;
    logic [6:0] firing_rate;
    logic [9:0] plant_load;
    logic [3:0] lit;
    int fails = 0, compares = 0, e;
    int order_q[$];
    bps_staging_ctrl #(.TICK_CYCLES(20), .REPEAT_CYCLES(8)) i_bps_staging_ctrl (.aclk, .aresetn,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .keys_pin,
        .supply_temp, .reset_setpoint, .external_setpoint, .boiler_fire, .firing_rate,
        .plant_load);
    bps_boiler_model i_bps_boiler_model (.aclk, .boiler_fire, .lit);
    initial forever #5 aclk = ~aclk;
    // ********************
    // tasks
    // ********************
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    // handshakes are sampled at the negedge, stable up to the next posedge
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic ha, hw, hb;
        awaddr <= a;
        wdata <= v;
        awvalid <= '1;
        wvalid <= '1;
        bready <= '1;
        forever begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            @(posedge aclk);
            if (ha) awvalid <= '0;
            if (hw) wvalid <= '0;
            if (hb) begin
                bready <= '0;
                break;
            end
        end
        // one edge between transfers, so the next call never re-raises bready in this step
        @(posedge aclk);
    endtask
    task rd(input logic [7:0] a);
        logic ha, h;
        araddr <= a;
        arvalid <= '1;
        rready <= '1;
        forever begin
            @(negedge aclk);
            ha = arvalid && arready;
            h = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ha) arvalid <= '0;
            if (h) begin
                rready <= '0;
                break;
            end
        end
        @(posedge aclk);
    endtask
    task wait_fire(input logic [7:0] x);
        for (int k = 0; k < 2000; k++) begin
            @(negedge aclk);
            if (boiler_fire === x) break;
        end
        chk("boiler_fire", 32'(x), 32'(boiler_fire));
        @(posedge aclk);
    endtask
    // key held past the synchroniser, short of the repeat interval
    task press(input int b);
        keys_pin[b] <= '1;
        repeat (5) @(posedge aclk);
        keys_pin[b] <= '0;
        repeat (5) @(posedge aclk);
    endtask
    task give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ********************
    // tests
    // ********************
    initial begin
        e = $urandom(32'h2a54_affc);
        repeat (5) @(posedge aclk);
        aresetn <= '1;
        rd(OFF_LEVELS);
        chk("levels", 32'h0000_122D, d);
        rd(OFF_CONFIG);
        chk("config", 32'h0000_0001, d);
        rd(8'h18);
        chk("rresp", 32'h0000_0002, 32'(r));
        wr(OFF_LEVELS, 32'h0000_1264);
        rd(OFF_LEVELS);
        chk("levels", 32'h0000_1264, d);
        wr(OFF_LEVELS, 32'h0000_062D);
        wr(OFF_PID, 32'h0000_0032);
        wr(OFF_SETPT, 32'h0000_00B4);
        wr(OFF_CONFIG, 32'h0000_0021);
        wr(OFF_PRESENT, 32'h0000_00FF);
        supply_temp <= 10'h0A0;
        wait_fire(8'h01);
        order_q.push_back(0);
        supply_temp <= 10'h096;
        repeat (300) @(posedge aclk);
        chk("early", 32'h0000_0001, 32'(boiler_fire));
        wait_fire(8'h03);
        order_q.push_back(1);
        repeat (3) @(posedge aclk);
        chk("rate", 32'h0000_001E, 32'(firing_rate));
        supply_temp <= 10'h0AF;
        e = order_q.pop_front();
        wait_fire(8'h03 ^ (8'h01 << e));
        wr(OFF_LEVELS, 32'h0000_122D);
        wait_fire(8'h00);
        wr(OFF_CONFIG, 32'h0000_0020);
        supply_temp <= 10'h0A0;
        wait_fire(8'hFF);
        @(negedge aclk);
        chk("lit", 32'h0000_0008, 32'(lit));
        @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            e = $urandom % 41;
            supply_temp <= 10'h0B4 - 10'(e);
            repeat (6) @(posedge aclk);
            rd(OFF_STATUS);
            chk("load", 32'(e * 100 / 50), 32'(d[25:16]));
        end
        wr(OFF_CONFIG, 32'h0000_003E);
        rd(OFF_CONFIG);
        chk("config", 32'h0000_0032, d);
        wr(OFF_CONFIG, 32'h0000_0026);
        wr(OFF_PRESENT, 32'h0000_00C0);
        // the random loop may leave the load below stage-out; restore a known demand
        supply_temp <= 10'h0A0;
        wait_fire(8'h40);
        wr(OFF_CONFIG, 32'h0000_01C1);
        rd(OFF_CONFIG);
        chk("config", 32'h0000_0141, d);
        press(KEY_SCHEME);
        press(KEY_UP);
        rd(OFF_CONFIG);
        chk("config", 32'h0000_0142, d);
        press(KEY_SCHEME);
        press(KEY_UP);
        rd(OFF_CONFIG);
        chk("config", 32'h0000_0146, d);
        // held key: one press plus repeats, count saturates at four
        keys_pin[KEY_UP] <= '1;
        repeat (40) @(posedge aclk);
        keys_pin[KEY_UP] <= '0;
        repeat (5) @(posedge aclk);
        rd(OFF_CONFIG);
        chk("config", 32'h0000_0152, d);
        press(KEY_SETPT);
        press(KEY_UP);
        rd(OFF_CONFIG);
        chk("config", 32'h0000_0112, d);
        press(KEY_SETPT);
        press(KEY_UP);
        rd(OFF_CONFIG);
        chk("config", 32'h0000_0192, d);
        give_verdict();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        fails++;
        give_verdict();
    end
endmodule // testbench

// >>> inc/bps_pkg.sv
// bps_pkg: constants, enums and register layouts of the boiler staging block
// assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus
package bps_pkg;
    // ********************
    // timing
    // ********************
    localparam int CLK_KHZ      = 100_000;
    localparam int TICK_MS      = 1000;
    localparam int TICK_CYC     = TICK_MS * CLK_KHZ / 1000 * 1000;
    localparam int REPEAT_MS    = 100;
    localparam int REPEAT_CYC   = REPEAT_MS * CLK_KHZ;
    localparam logic [4:0] STAGE_DELAY_S = 5'h1E;

    // ********************
    // limits and reset values
    // ********************
    localparam int NUM_CH       = 8;
    localparam int PROP_LIM     = 800;
    localparam int PCT_SCALE    = 100;
    localparam int INTEG_SCALE  = 6000;
    localparam logic [31:0] INTEG_MAX   = 32'h0049_3E00;
    localparam logic [6:0]  PCT_MAX     = 7'h64;
    localparam logic [6:0]  STAGE_IN_RST  = 7'h2D;
    localparam logic [6:0]  STAGE_OUT_RST = 7'h12;
    localparam logic [2:0]  HW_MAX      = 3'h4;
    localparam logic [9:0]  BAND_RST    = 10'h032;
    localparam logic [9:0]  GAIN_RST    = 10'h00F;
    localparam logic [9:0]  FIXED_SP_RST = 10'h0B4;

    // ********************
    // register map
    // ********************
    localparam logic [7:0] OFF_CONFIG  = 8'h00;
    localparam logic [7:0] OFF_LEVELS  = 8'h04;
    localparam logic [7:0] OFF_PID     = 8'h08;
    localparam logic [7:0] OFF_SETPT   = 8'h0C;
    localparam logic [7:0] OFF_PRESENT = 8'h10;
    localparam logic [7:0] OFF_STATUS  = 8'h14;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int KEY_UP = 0;
    localparam int KEY_DOWN = 1;
    localparam int KEY_SCHEME = 2;
    localparam int KEY_SETPT = 3;

    typedef enum logic [1:0] {SCH_PARALLEL = 2'b00, SCH_SEQUENTIAL = 2'b01,
                              SCH_MIXED = 2'b10} bps_scheme_t;
    typedef enum logic [1:0] {SP_RESET = 2'b00, SP_FIXED = 2'b01,
                              SP_EXTERNAL = 2'b10} bps_spsrc_t;
    typedef enum logic [2:0] {ED_NONE = 3'b000, ED_SCHEME = 3'b001, ED_HWCNT = 3'b010,
                              ED_SPSRC = 3'b011, ED_SENSOR = 3'b100} bps_edit_t;

    typedef struct packed {
        logic setpt;
        logic scheme;
        logic down;
        logic up;
    } bps_keys_t;

    typedef struct packed {
        logic [22:0] pad;
        logic        indoor_used;
        logic        sensor_420;
        bps_spsrc_t  sp_src;
        logic [2:0]  hw_cnt;
        bps_scheme_t scheme;
    } bps_cfg_t;

    typedef struct packed {
        logic [16:0] pad1;
        logic [6:0]  stage_out;
        logic        pad0;
        logic [6:0]  stage_in;
    } bps_lvl_t;

    typedef struct packed {
        logic [5:0] pad1;
        logic [9:0] gain;
        logic [5:0] pad0;
        logic [9:0] band;
    } bps_pid_t;

    typedef struct packed {
        bps_cfg_t         cfg;
        bps_lvl_t         lvl;
        bps_pid_t         pid;
        logic [9:0]       fixed_sp;
        logic [7:0]       present;
        bps_edit_t        edit;
        logic [3:0]       key_s1;
        logic [3:0]       key_s2;
        logic [3:0]       key_prev;
        logic [31:0]      rep_cnt;
        logic [31:0]      tick_cnt;
        logic [4:0]       delay_cnt;
        logic [31:0]      integ;
        logic [7:0]       firing;
        logic [7:0][2:0]  order;
        logic [3:0]       n;
        logic [6:0]       rate;
        logic [9:0]       load;
        logic             aw_ok;
        logic [7:0]       aw_addr;
        logic             w_ok;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } bps_state_t;
endpackage

// >>> rtl/bps_staging_ctrl.sv
// bps_staging_ctrl: boiler plant staging, key editing, proportional/integral load
// assumes keys arrive asynchronously; temperatures come from logic on aclk
//
// What this block does
// RULE1: stage-in resets to 45%, stage-out 18%
// RULE2: stage-in accepts up to 100%, no 60% cap
// RULE3: scheme cycles parallel/sequential/mixed, resets sequential
// RULE4: sequential: start one boiler when demand appears
// RULE5: one boiler at stage-in: second after 30 s
// RULE6: all at stage-in: add one after 30 s
// RULE7: all at stage-out: stop earliest started boiler
// RULE8: stop one at a time, last at stage-out
// RULE9: parallel fires all, ignores stage levels
// RULE10: hot-water boiler count at most four
// RULE11: hot-water group sits on highest channels
// RULE12: scheme key again in mixed edits count
// RULE13: setpoint source cycles reset/fixed/external
// RULE14: second setpoint key press toggles sensor type
// RULE15: external setpoint with indoor sensor forces thermistor
// RULE16: demand equals error times 100 over band
// RULE17: held up/down keys repeat fast
// RULE18: integral adds demand times gain over time
// RULE19: 30 s delay counts seconds, clears on loss
// RULE20: start order kept so oldest stops first
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module bps_staging_ctrl import bps_pkg::*; #(
    parameter int TICK_CYCLES   = TICK_CYC,
    parameter int REPEAT_CYCLES = REPEAT_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire bps_keys_t   keys_pin,
    input  wire logic [9:0]  supply_temp,
    input  wire logic [9:0]  reset_setpoint,
    input  wire logic [9:0]  external_setpoint,
    output logic [7:0]       boiler_fire,
    output logic [6:0]       firing_rate,
    output logic [9:0]       plant_load
);
    // ********************
    // helpers
    // ********************
    function automatic logic reg_hit(input logic [7:0] a);
        case ({a[7:2], 2'b00})
            OFF_CONFIG, OFF_LEVELS, OFF_PID, OFF_SETPT, OFF_PRESENT, OFF_STATUS: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] read_word(input bps_state_t s, input logic [7:0] a);
        case ({a[7:2], 2'b00})
            OFF_CONFIG:  read_word = s.cfg;
            OFF_LEVELS:  read_word = s.lvl;
            OFF_PID:     read_word = s.pid;
            OFF_SETPT:   read_word = {22'h00_0000, s.fixed_sp};
            OFF_PRESENT: read_word = {24'h00_0000, s.present};
            OFF_STATUS:  read_word = {6'h00, s.load, 1'b0, s.rate, s.firing};
            default:     read_word = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            merge[8*b +: 8] = s[b] ? v[8*b +: 8] : o[8*b +: 8];
        end
    endfunction

    // cyclic step through three codes, shared by scheme and setpoint source
    function automatic logic [1:0] step3(input logic [1:0] v, input logic up);
        if (up) begin
            step3 = (v == 2'h2) ? 2'h0 : v + 2'h1;
        end else begin
            step3 = (v == 2'h0) ? 2'h2 : v - 2'h1;
        end
    endfunction

    function automatic logic [2:0] first_free(input logic [7:0] m);
        first_free = 3'h0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (m[i]) first_free = 3'(i);
        end
    endfunction

    bps_state_t         st;
    bps_state_t         next_st;
    logic [9:0]         setpoint;
    logic [9:0]         band_nz;
    logic signed [11:0] temp_err;
    logic signed [31:0] prop_raw;
    logic signed [11:0] prop_pct;
    logic [31:0]        load_sum;
    logic [9:0]         load;
    logic signed [33:0] integ_sum;
    logic [7:0]         hw_mask;
    logic [7:0]         elig;
    logic [7:0]         free;
    logic [9:0]         per_boiler;
    logic [6:0]         cur_rate;
    logic               stage_in_cond;
    logic               tick_hit;
    logic               rep_hit;

    // ********************
    // demand
    // ********************
    assign setpoint = (st.cfg.sp_src == SP_FIXED) ? st.fixed_sp :
                      (st.cfg.sp_src == SP_EXTERNAL) ? external_setpoint : reset_setpoint; // RULE13
    assign band_nz  = (st.pid.band == 10'h000) ? 10'h001 : st.pid.band;
    assign temp_err = $signed({2'b00, setpoint}) - $signed({2'b00, supply_temp});
    assign prop_raw = (32'(temp_err) * PCT_SCALE) / $signed({22'h00_0000, band_nz}); // RULE16
    assign prop_pct = (prop_raw > PROP_LIM) ? 12'(PROP_LIM) :
                      (prop_raw < -PROP_LIM) ? 12'(-PROP_LIM) : 12'(prop_raw);
    assign load_sum = ((prop_pct > 0) ? 32'(prop_pct) : 32'h0000_0000) + st.integ / INTEG_SCALE;
    assign load     = (load_sum > PROP_LIM) ? 10'(PROP_LIM) : load_sum[9:0];
    assign integ_sum = $signed({2'b00, st.integ}) + 34'(prop_pct) * $signed({24'h00_0000, st.pid.gain});

    // ********************
    // channel groups
    // ********************
    for (genvar i = 0; i < NUM_CH; i++) begin : g_hw
        assign hw_mask[i] = (4'(i) + {1'b0, st.cfg.hw_cnt}) >= 4'h8; // RULE11
    end
    assign elig = st.present & ~((st.cfg.scheme == SCH_MIXED) ? hw_mask : 8'h00);
    assign free = elig & ~st.firing;
    assign per_boiler = (st.n == 4'h0) ? 10'h000 : 10'(st.load / {6'h00, st.n});
    assign cur_rate = (per_boiler > {3'h0, PCT_MAX}) ? PCT_MAX : per_boiler[6:0];
    assign stage_in_cond = (st.n != 4'h0) && (cur_rate >= st.lvl.stage_in) && (free != 8'h00);
    assign tick_hit = st.tick_cnt == 32'(TICK_CYCLES - 1);
    assign rep_hit  = st.rep_cnt == 32'(REPEAT_CYCLES - 1);

    always_comb begin
        logic [3:0]  press;
        logic        step_up;
        logic        step_dn;
        logic [31:0] wr;
        bps_cfg_t    wcfg;
        bps_lvl_t    wlvl;
        logic [2:0]  idx;
        press   = st.key_s2 & ~st.key_prev;
        step_up = press[KEY_UP] | (st.key_s2[KEY_UP] & rep_hit); // RULE17
        step_dn = press[KEY_DOWN] | (st.key_s2[KEY_DOWN] & rep_hit); // RULE17
        wr      = merge(read_word(st, st.aw_addr), st.w_data, st.w_strb);
        wcfg    = wr;
        wlvl    = wr;
        idx     = first_free(free);
        next_st = st;
        next_st.key_s1   = keys_pin;
        next_st.key_s2   = st.key_s1;
        next_st.key_prev = st.key_s2;
        // the repeat timer runs only while the up or down key is held
        next_st.rep_cnt  = (st.key_s2[KEY_UP] | st.key_s2[KEY_DOWN]) ?
                           (rep_hit ? 32'h0000_0000 : st.rep_cnt + 32'h0000_0001) : 32'h0000_0000;

        // ********************
        // key editing
        // ********************
        if (press[KEY_SCHEME]) begin
            next_st.edit = (st.edit == ED_SCHEME && st.cfg.scheme == SCH_MIXED) ?
                           ED_HWCNT : ED_SCHEME; // RULE12
        end else if (press[KEY_SETPT]) begin
            next_st.edit = (st.edit == ED_SPSRC) ? ED_SENSOR : ED_SPSRC; // RULE14
        end else if (step_up | step_dn) begin
            case (st.edit)
                ED_SCHEME: next_st.cfg.scheme = bps_scheme_t'(step3(st.cfg.scheme, step_up)); // RULE3
                ED_HWCNT: begin
                    if (step_up && st.cfg.hw_cnt < HW_MAX) next_st.cfg.hw_cnt = st.cfg.hw_cnt + 3'h1; // RULE10
                    if (step_dn && st.cfg.hw_cnt != 3'h0) next_st.cfg.hw_cnt = st.cfg.hw_cnt - 3'h1;
                end
                ED_SPSRC:  next_st.cfg.sp_src = bps_spsrc_t'(step3(st.cfg.sp_src, step_up)); // RULE13
                ED_SENSOR: next_st.cfg.sensor_420 = ~st.cfg.sensor_420; // RULE14
                default: ;
            endcase
        end

        // ********************
        // axi4-lite slave
        // ********************
        if (awvalid && awready) begin
            next_st.aw_ok   = 1'b1;
            next_st.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_st.w_ok   = 1'b1;
            next_st.w_data = wdata;
            next_st.w_strb = wstrb;
        end
        if (st.aw_ok && st.w_ok && !st.bvalid) begin
            next_st.aw_ok  = 1'b0;
            next_st.w_ok   = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = reg_hit(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            case ({st.aw_addr[7:2], 2'b00})
                OFF_CONFIG: begin
                    // the unused fourth code is refused so the selectors stay legal
                    if (wcfg.scheme != 2'b11) next_st.cfg.scheme = wcfg.scheme; // RULE3
                    if (wcfg.sp_src != 2'b11) next_st.cfg.sp_src = wcfg.sp_src;
                    next_st.cfg.hw_cnt = (wcfg.hw_cnt > HW_MAX) ? HW_MAX : wcfg.hw_cnt; // RULE10
                    next_st.cfg.sensor_420  = wcfg.sensor_420;
                    next_st.cfg.indoor_used = wcfg.indoor_used;
                end
                OFF_LEVELS: begin
                    next_st.lvl.stage_in  = (wlvl.stage_in > PCT_MAX) ? PCT_MAX : wlvl.stage_in; // RULE2
                    next_st.lvl.stage_out = (wlvl.stage_out > PCT_MAX) ? PCT_MAX : wlvl.stage_out;
                end
                OFF_PID: begin
                    next_st.pid.band = wr[9:0];
                    next_st.pid.gain = wr[25:16];
                end
                OFF_SETPT:   next_st.fixed_sp = wr[9:0];
                OFF_PRESENT: next_st.present  = wr[7:0];
                default: ;
            endcase
        end
        if (st.bvalid && bready) next_st.bvalid = 1'b0;
        if (arvalid && arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = read_word(st, araddr);
            next_st.rresp  = reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (st.rvalid && rready) next_st.rvalid = 1'b0;
        if (next_st.cfg.sp_src == SP_EXTERNAL && next_st.cfg.indoor_used) begin
            next_st.cfg.sensor_420 = 1'b0; // RULE15
        end

        // ********************
        // integral and load
        // ********************
        next_st.tick_cnt = tick_hit ? 32'h0000_0000 : st.tick_cnt + 32'h0000_0001;
        if (tick_hit) begin
            next_st.integ = (integ_sum < 0) ? 32'h0000_0000 :
                            (integ_sum > $signed({2'b00, INTEG_MAX})) ? INTEG_MAX : integ_sum[31:0]; // RULE18
        end
        next_st.load = load;
        next_st.rate = cur_rate;

        // ********************
        // staging
        // ********************
        // a changed group or scheme restarts staging from nothing; simpler than remapping
        if (next_st.cfg.scheme != st.cfg.scheme || next_st.cfg.hw_cnt != st.cfg.hw_cnt ||
            next_st.present != st.present) begin
            next_st.firing    = 8'h00;
            next_st.n         = 4'h0;
            next_st.delay_cnt = 5'h00;
        end else if (st.cfg.scheme == SCH_PARALLEL) begin
            next_st.firing    = (st.load != 10'h000) ? elig : 8'h00; // RULE9
            next_st.n         = 4'($countones(next_st.firing));
            next_st.delay_cnt = 5'h00;
        end else begin
            next_st.delay_cnt = !stage_in_cond ? 5'h00 :
                                (tick_hit && st.delay_cnt != STAGE_DELAY_S) ?
                                st.delay_cnt + 5'h01 : st.delay_cnt; // RULE19
            if (st.n == 4'h0) begin
                if (st.load > {3'h0, st.lvl.stage_out} && free != 8'h00) begin
                    next_st.firing[idx] = 1'b1; // RULE4
                    next_st.order[0]    = idx;
                    next_st.n           = 4'h1;
                end
            end else if (stage_in_cond) begin
                if (st.delay_cnt == STAGE_DELAY_S) begin
                    next_st.firing[idx]        = 1'b1; // RULE5 RULE6
                    next_st.order[st.n[2:0]]   = idx; // RULE20
                    next_st.n                  = st.n + 4'h1;
                    next_st.delay_cnt          = 5'h00;
                end
            end else if (cur_rate <= st.lvl.stage_out) begin
                next_st.firing[st.order[0]] = 1'b0; // RULE7 RULE8
                for (int i = 0; i < NUM_CH - 1; i++) begin
                    next_st.order[i] = st.order[i+1]; // RULE20
                end
                next_st.n = st.n - 4'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st                <= '0;
            st.cfg.scheme     <= SCH_SEQUENTIAL; // RULE3
            st.lvl.stage_in   <= STAGE_IN_RST; // RULE1
            st.lvl.stage_out  <= STAGE_OUT_RST; // RULE1
            st.pid.band       <= BAND_RST;
            st.pid.gain       <= GAIN_RST;
            st.fixed_sp       <= FIXED_SP_RST;
        end else begin
            st <= next_st;
        end
    end

    assign awready     = !st.aw_ok && !st.bvalid;
    assign wready      = !st.w_ok && !st.bvalid;
    assign arready     = !st.rvalid;
    assign bvalid      = st.bvalid;
    assign bresp       = st.bresp;
    assign rvalid      = st.rvalid;
    assign rdata       = st.rdata;
    assign rresp       = st.rresp;
    assign boiler_fire = st.firing;
    assign firing_rate = st.rate;
    assign plant_load  = st.load;

    // ********************
    // checks
    // ********************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_reset_levels: assert property ($past(!aresetn) |-> st.lvl.stage_in == 7'h2D // RULE1
        && st.lvl.stage_out == 7'h12) else $error("stage levels wrong after reset");
    chk_level_range: assert property (st.lvl.stage_in <= PCT_MAX // RULE2
        && st.lvl.stage_out <= PCT_MAX) else $error("stage level above 100");
    chk_scheme_legal: assert property (($past(!aresetn) |-> st.cfg.scheme == SCH_SEQUENTIAL) // RULE3
        and st.cfg.scheme != 2'b11) else $error("scheme code illegal");
    chk_first_start: assert property (st.cfg.scheme == SCH_SEQUENTIAL && st.n == 4'h0 // RULE4
        && st.load > {3'h0, st.lvl.stage_out} && free != 8'h00 && next_st.cfg == st.cfg
        && next_st.present == st.present |=> st.n == 4'h1 && $countones(st.firing) == 1)
        else $error("first boiler not started");
    chk_stage_delay: assert property (st.n != 4'h0 && next_st.n > st.n // RULE6
        && st.cfg.scheme != SCH_PARALLEL |-> st.delay_cnt == 5'h1E)
        else $error("boiler added before delay ran out");
    chk_delay_clear: assert property (!stage_in_cond |=> st.delay_cnt == 5'h00) // RULE19
        else $error("stage delay not cleared");
    chk_stop_oldest: assert property (st.cfg.scheme != SCH_PARALLEL && next_st.n < st.n // RULE7
        && next_st.firing != 8'h00 |=> !st.firing[$past(st.order[0])])
        else $error("stopped boiler was not the oldest");
    chk_parallel_all: assert property (st.cfg.scheme == SCH_PARALLEL && next_st.cfg == st.cfg // RULE9
        && next_st.present == st.present && st.load != 10'h000 |=> st.firing == $past(elig))
        else $error("parallel did not fire all boilers");
    chk_hw_limit: assert property (st.cfg.hw_cnt <= HW_MAX) else $error("too many hot-water"); // RULE10
    chk_hw_group: assert property (st.cfg.scheme == SCH_MIXED |-> (st.firing & hw_mask) == 8'h00) // RULE11
        else $error("hot-water channel staged");
    chk_sensor_forced: assert property (st.cfg.sp_src == SP_EXTERNAL && st.cfg.indoor_used // RULE15
        |-> !st.cfg.sensor_420) else $error("current loop sensor with external setpoint");

    cov_second_start: cover property (st.n == 4'h1 ##1 st.n == 4'h2);
    cov_stage_out: cover property (st.n == 4'h2 ##1 st.n == 4'h1);
    cov_parallel: cover property (st.cfg.scheme == SCH_PARALLEL && st.n > 4'h1);
    cov_hw_edit: cover property (st.edit == ED_HWCNT && st.cfg.hw_cnt == HW_MAX);
endmodule // bps_staging_ctrl
